// ### logic/brf_map.svh
`ifndef BRF_MAP_SVH
`define BRF_MAP_SVH

// ==========================================================================
// Register port address map
// ==========================================================================
`define BRF_ADDR_W 4
`define BRF_ADR_DATA_ZERO 4'h0
`define BRF_ADR_DATA_ONE 4'h1
`define BRF_ADR_DATA_TWO 4'h2
`define BRF_ADR_DATA_THREE 4'h3
`define BRF_ADR_ADDR_ZERO 4'h4
`define BRF_ADR_ADDR_ONE 4'h5
`define BRF_ADR_FRAME_BASE 4'h6
`define BRF_ADR_ZERO_LOWER 4'h8
`define BRF_ADR_ZERO_UPPER 4'h9
`define BRF_ADR_ONE_LOWER 4'ha
`define BRF_ADR_ONE_UPPER 4'hb
`define BRF_ADR_PAIR_LOW_WIDE 4'hc
`define BRF_ADR_PAIR_HIGH_WIDE 4'hd
`define BRF_ADR_ADDR_PAIR_WIDE 4'he
`define BRF_ADR_STATUS 4'hf

// ==========================================================================
// Sizes and reset values
// ==========================================================================
`define BRF_CORE_REGS 13
`define BRF_BANKED_REGS 7
`define BRF_BANKS 2
`define BRF_WORD_W 16
`define BRF_BUS_W 32
`define BRF_RESET_WORD 16'h0000
`define BRF_RESET_BUS 32'h0000_0000

`endif

// ### logic/brf_pkg.sv
package brf_pkg;

  // ========================================================================
  // Types
  // ========================================================================
  typedef logic [15:0] brf_word_t;

  // Position of each banked register inside one bank copy.
  typedef enum logic [2:0] {
    BRF_DATA_ZERO,
    BRF_DATA_ONE,
    BRF_DATA_TWO,
    BRF_DATA_THREE,
    BRF_ADDR_ZERO,
    BRF_ADDR_ONE,
    BRF_FRAME_BASE
  } brf_slot_e;

endpackage

// ### logic/brf_bank_regs.sv
// Behaviour
// - Four data, two address and frame base registers form the bank.
// - Two independent bank copies exist; only one serves accesses.
// - Four 16-bit data registers are readable and writable.
// - First two data registers have byte halves; byte write keeps other.
// - Third with first and fourth with second data form 32-bit pairs.
// - Two 16-bit address registers supply indirect and relative bases.
// - Address registers also serve as ordinary read/write operands.
// - Both address registers join into one 32-bit address pair.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "brf_map.svh"

module brf_bank_regs #(
  parameter int BANKS = `BRF_BANKS,
  parameter int REGS = `BRF_BANKED_REGS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic bank_sel,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata_q,
  output logic [15:0] addr_base_zero_q,
  output logic [15:0] addr_base_one_q,
  output logic active_bank_q
);

  // ========================================================================
  // Storage
  // ========================================================================
  brf_pkg::brf_word_t regs_q [0:BANKS-1][0:REGS-1];

  // ========================================================================
  // Decode
  // ========================================================================
  // Byte lanes of one slot touched by a write at address a.
  function automatic logic [1:0] wr_lanes(input logic [3:0] a,
                                          input int unsigned slot);
    logic [1:0] lanes;
    lanes = 2'b00;
    case (a)
      `BRF_ADR_DATA_ZERO: begin
        if (slot == int'(brf_pkg::BRF_DATA_ZERO)) lanes = 2'b11;
      end
      `BRF_ADR_DATA_ONE: begin
        if (slot == int'(brf_pkg::BRF_DATA_ONE)) lanes = 2'b11;
      end
      `BRF_ADR_DATA_TWO: begin
        if (slot == int'(brf_pkg::BRF_DATA_TWO)) lanes = 2'b11;
      end
      `BRF_ADR_DATA_THREE: begin
        if (slot == int'(brf_pkg::BRF_DATA_THREE)) lanes = 2'b11;
      end
      `BRF_ADR_ADDR_ZERO: begin
        if (slot == int'(brf_pkg::BRF_ADDR_ZERO)) lanes = 2'b11;
      end
      `BRF_ADR_ADDR_ONE: begin
        if (slot == int'(brf_pkg::BRF_ADDR_ONE)) lanes = 2'b11;
      end
      `BRF_ADR_FRAME_BASE: begin
        if (slot == int'(brf_pkg::BRF_FRAME_BASE)) lanes = 2'b11;
      end
      `BRF_ADR_ZERO_LOWER: begin
        if (slot == int'(brf_pkg::BRF_DATA_ZERO)) lanes = 2'b01;
      end
      `BRF_ADR_ZERO_UPPER: begin
        if (slot == int'(brf_pkg::BRF_DATA_ZERO)) lanes = 2'b10;
      end
      `BRF_ADR_ONE_LOWER: begin
        if (slot == int'(brf_pkg::BRF_DATA_ONE)) lanes = 2'b01;
      end
      `BRF_ADR_ONE_UPPER: begin
        if (slot == int'(brf_pkg::BRF_DATA_ONE)) lanes = 2'b10;
      end
      `BRF_ADR_PAIR_LOW_WIDE: begin
        if (slot == int'(brf_pkg::BRF_DATA_TWO) ||
            slot == int'(brf_pkg::BRF_DATA_ZERO)) lanes = 2'b11;
      end
      `BRF_ADR_PAIR_HIGH_WIDE: begin
        if (slot == int'(brf_pkg::BRF_DATA_THREE) ||
            slot == int'(brf_pkg::BRF_DATA_ONE)) lanes = 2'b11;
      end
      `BRF_ADR_ADDR_PAIR_WIDE: begin
        if (slot == int'(brf_pkg::BRF_ADDR_ONE) ||
            slot == int'(brf_pkg::BRF_ADDR_ZERO)) lanes = 2'b11;
      end
      default: begin
        lanes = 2'b00;
      end
    endcase
    return lanes;
  endfunction

  // Value offered to one slot; the lane mask picks which bytes land.
  function automatic brf_pkg::brf_word_t wr_value(input logic [3:0] a,
                                                  input int unsigned slot,
                                                  input logic [31:0] wd);
    brf_pkg::brf_word_t v;
    v = wd[15:0];
    case (a)
      `BRF_ADR_ZERO_UPPER, `BRF_ADR_ONE_UPPER: begin
        v = {wd[7:0], wd[7:0]};
      end
      `BRF_ADR_PAIR_LOW_WIDE, `BRF_ADR_PAIR_HIGH_WIDE,
      `BRF_ADR_ADDR_PAIR_WIDE: begin
        if (slot == int'(brf_pkg::BRF_DATA_TWO) ||
            slot == int'(brf_pkg::BRF_DATA_THREE) ||
            slot == int'(brf_pkg::BRF_ADDR_ONE)) v = wd[31:16];
      end
      default: begin
        v = wd[15:0];
      end
    endcase
    return v;
  endfunction

  // ========================================================================
  // Bank storage
  // ========================================================================
  // Each access uses the bank select seen beside its strobe, so a switch
  // lands on the very next access and never splits one access.
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    for (genvar i = 0; i < REGS; i++) begin : g_reg
      logic [1:0] lanes;
      brf_pkg::brf_word_t val;
      assign lanes = wr_lanes(addr, i);
      assign val = wr_value(addr, i, wdata);
      always_ff @(posedge clk) begin
        if (reset) begin
          regs_q[b][i] <= `BRF_RESET_WORD;
        end else if (wr_stb && (32'(bank_sel) == b)) begin
          if (lanes[0]) begin
            regs_q[b][i][7:0] <= val[7:0];
          end
          if (lanes[1]) begin
            regs_q[b][i][15:8] <= val[15:8];
          end
        end
      end
    end
  end

  // ========================================================================
  // Read port
  // ========================================================================
  brf_pkg::brf_word_t cur [0:REGS-1];
  logic [31:0] rd_val;

  always_comb begin
    for (int i = 0; i < REGS; i++) begin
      cur[i] = regs_q[bank_sel][i];
    end
  end

  always_comb begin
    rd_val = `BRF_RESET_BUS;
    case (addr)
      `BRF_ADR_DATA_ZERO: rd_val = {16'h0000, cur[0]};
      `BRF_ADR_DATA_ONE: rd_val = {16'h0000, cur[1]};
      `BRF_ADR_DATA_TWO: rd_val = {16'h0000, cur[2]};
      `BRF_ADR_DATA_THREE: rd_val = {16'h0000, cur[3]};
      `BRF_ADR_ADDR_ZERO: rd_val = {16'h0000, cur[4]};
      `BRF_ADR_ADDR_ONE: rd_val = {16'h0000, cur[5]};
      `BRF_ADR_FRAME_BASE: rd_val = {16'h0000, cur[6]};
      `BRF_ADR_ZERO_LOWER: rd_val = {24'h00_0000, cur[0][7:0]};
      `BRF_ADR_ZERO_UPPER: rd_val = {24'h00_0000, cur[0][15:8]};
      `BRF_ADR_ONE_LOWER: rd_val = {24'h00_0000, cur[1][7:0]};
      `BRF_ADR_ONE_UPPER: rd_val = {24'h00_0000, cur[1][15:8]};
      `BRF_ADR_PAIR_LOW_WIDE: rd_val = {cur[2], cur[0]};
      `BRF_ADR_PAIR_HIGH_WIDE: rd_val = {cur[3], cur[1]};
      `BRF_ADR_ADDR_PAIR_WIDE: rd_val = {cur[5], cur[4]};
      `BRF_ADR_STATUS: rd_val = {31'h0000_0000, active_bank_q};
      default: rd_val = `BRF_RESET_BUS;
    endcase
  end

  // Read data stand for exactly one cycle; idle cycles show zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= `BRF_RESET_BUS;
    end else if (rd_stb) begin
      rdata_q <= rd_val;
    end else begin
      rdata_q <= `BRF_RESET_BUS;
    end
  end

  // ========================================================================
  // Addressing bases and status
  // ========================================================================
  // The bases trail the active copy by one cycle; a flop here keeps the
  // address adder off the write path at the cost of that latency.
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_base_zero_q <= `BRF_RESET_WORD;
      addr_base_one_q <= `BRF_RESET_WORD;
    end else begin
      addr_base_zero_q <= cur[brf_pkg::BRF_ADDR_ZERO];
      addr_base_one_q <= cur[brf_pkg::BRF_ADDR_ONE];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      active_bank_q <= 1'b0;
    end else begin
      active_bank_q <= bank_sel;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  property p_frame_banked;
    @(posedge clk) disable iff (reset)
    (wr_stb && bank_sel && addr == `BRF_ADR_FRAME_BASE) |=>
      (regs_q[1][brf_pkg::BRF_FRAME_BASE] == $past(wdata[15:0])) &&
      $stable(regs_q[0][brf_pkg::BRF_FRAME_BASE]);
  endproperty
  a_frame_banked: assert property (p_frame_banked)
    else $error("frame base write leaked into the idle bank");

  property p_bank_isolate;
    @(posedge clk) disable iff (reset)
    (wr_stb && !bank_sel) |=>
      $stable(regs_q[1][brf_pkg::BRF_DATA_ZERO]) &&
      $stable(regs_q[1][brf_pkg::BRF_ADDR_ONE]);
  endproperty
  a_bank_isolate: assert property (p_bank_isolate)
    else $error("write to bank zero changed bank one");

  property p_word_rw;
    @(posedge clk) disable iff (reset)
    (wr_stb && addr == `BRF_ADR_DATA_THREE) ##1
    (rd_stb && addr == `BRF_ADR_DATA_THREE && $stable(bank_sel)) |=>
      rdata_q == {16'h0000, $past(wdata[15:0], 2)};
  endproperty
  a_word_rw: assert property (p_word_rw)
    else $error("data register read did not return written word");

  property p_rd_idle;
    @(posedge clk) disable iff (reset)
    !rd_stb |=> rdata_q == `BRF_RESET_BUS;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data held beyond its single cycle");

  property p_byte_keep;
    @(posedge clk) disable iff (reset)
    (wr_stb && !bank_sel && addr == `BRF_ADR_ZERO_LOWER) |=>
      (regs_q[0][brf_pkg::BRF_DATA_ZERO][15:8] ==
       $past(regs_q[0][brf_pkg::BRF_DATA_ZERO][15:8])) &&
      (regs_q[0][brf_pkg::BRF_DATA_ZERO][7:0] == $past(wdata[7:0]));
  endproperty
  a_byte_keep: assert property (p_byte_keep)
    else $error("lower byte write disturbed the upper byte");

  property p_pair_read;
    @(posedge clk) disable iff (reset)
    (rd_stb && !bank_sel && addr == `BRF_ADR_PAIR_LOW_WIDE) |=>
      rdata_q == {$past(regs_q[0][brf_pkg::BRF_DATA_TWO]),
                  $past(regs_q[0][brf_pkg::BRF_DATA_ZERO])};
  endproperty
  a_pair_read: assert property (p_pair_read)
    else $error("wide data pair read in wrong order");

  property p_base_out;
    @(posedge clk) disable iff (reset)
    !bank_sel |=>
      addr_base_zero_q == $past(regs_q[0][brf_pkg::BRF_ADDR_ZERO]);
  endproperty
  a_base_out: assert property (p_base_out)
    else $error("address base does not follow active register");

  property p_addr_operand;
    @(posedge clk) disable iff (reset)
    (rd_stb && bank_sel && addr == `BRF_ADR_ADDR_ONE) |=>
      rdata_q == {16'h0000, $past(regs_q[1][brf_pkg::BRF_ADDR_ONE])};
  endproperty
  a_addr_operand: assert property (p_addr_operand)
    else $error("address register operand read is wrong");

  property p_addr_pair_write;
    @(posedge clk) disable iff (reset)
    (wr_stb && bank_sel && addr == `BRF_ADR_ADDR_PAIR_WIDE) |=>
      (regs_q[1][brf_pkg::BRF_ADDR_ONE] == $past(wdata[31:16])) &&
      (regs_q[1][brf_pkg::BRF_ADDR_ZERO] == $past(wdata[15:0]));
  endproperty
  a_addr_pair_write: assert property (p_addr_pair_write)
    else $error("wide address pair write split wrongly");

  property p_bank_switch;
    @(posedge clk) disable iff (reset)
    ($rose(bank_sel) && wr_stb && addr == `BRF_ADR_DATA_TWO) |=>
      (regs_q[1][brf_pkg::BRF_DATA_TWO] == $past(wdata[15:0])) &&
      $stable(regs_q[0][brf_pkg::BRF_DATA_TWO]) && active_bank_q;
  endproperty
  a_bank_switch: assert property (p_bank_switch)
    else $error("bank switch did not steer the next access");

  property p_byte_upper;
    @(posedge clk) disable iff (reset)
    (wr_stb && bank_sel && addr == `BRF_ADR_ONE_UPPER) |=>
      (regs_q[1][brf_pkg::BRF_DATA_ONE][15:8] == $past(wdata[7:0])) &&
      $stable(regs_q[1][brf_pkg::BRF_DATA_ONE][7:0]);
  endproperty
  a_byte_upper: assert property (p_byte_upper)
    else $error("upper byte write disturbed the lower byte");

  property p_base_one;
    @(posedge clk) disable iff (reset)
    bank_sel |=>
      addr_base_one_q == $past(regs_q[1][brf_pkg::BRF_ADDR_ONE]);
  endproperty
  a_base_one: assert property (p_base_one)
    else $error("second address base does not follow active copy");

  property p_high_pair_read;
    @(posedge clk) disable iff (reset)
    (rd_stb && bank_sel && addr == `BRF_ADR_PAIR_HIGH_WIDE) |=>
      rdata_q == {$past(regs_q[1][brf_pkg::BRF_DATA_THREE]),
                  $past(regs_q[1][brf_pkg::BRF_DATA_ONE])};
  endproperty
  a_high_pair_read: assert property (p_high_pair_read)
    else $error("upper wide data pair read in wrong order");

  property p_byte_read;
    @(posedge clk) disable iff (reset)
    (rd_stb && !bank_sel && addr == `BRF_ADR_ZERO_UPPER) |=>
      rdata_q == {24'h00_0000,
                  $past(regs_q[0][brf_pkg::BRF_DATA_ZERO][15:8])};
  endproperty
  a_byte_read: assert property (p_byte_read)
    else $error("upper byte read returned the wrong byte");

  property p_status_read;
    @(posedge clk) disable iff (reset)
    (rd_stb && addr == `BRF_ADR_STATUS) |=>
      rdata_q == {31'h0000_0000, $past(active_bank_q)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read does not show the active bank");

endmodule // brf_bank_regs

// ### dv/brf_core_model.sv
`timescale 1ns/10ps
// ==========================================================================
// Core datapath model driving the register port
// ==========================================================================
module brf_core_model (
  input wire logic clk,
  input wire logic [31:0] rdata_q,
  output logic bank_sel,
  output logic [3:0] addr,
  output logic [31:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  initial begin
    bank_sel = 1'b0;
    addr = 4'h7;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // Idle address and data are inverted so that a stray sample is caught.
  task automatic wr(input logic b, input logic [3:0] a,
                    input logic [31:0] v);
    @(posedge clk);
    bank_sel <= b;
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
  endtask

  task automatic rd(input logic b, input logic [3:0] a,
                    output logic [31:0] v);
    @(posedge clk);
    bank_sel <= b;
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1;
    v = rdata_q;
  endtask

  // Write then read the same address with no idle cycle between them.
  task automatic wr_rd(input logic b, input logic [3:0] a,
                       input logic [31:0] v, output logic [31:0] r);
    @(posedge clk);
    bank_sel <= b;
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
    #1;
    r = rdata_q;
  endtask
endmodule // brf_core_model

// ### dv/cpu_banked_register_file_test.sv
`timescale 1ns/10ps
`include "brf_map.svh"
module cpu_banked_register_file_test;
  logic clk;
  logic reset;
  logic bank_sel, wr_stb, rd_stb, act;
  logic [3:0] addr;
  logic [31:0] wdata, rdata_q, d, pv;
  logic [15:0] base0, base1;
  logic [15:0] sh [2][7];
  int miscompares, n_compared, cycles;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  brf_bank_regs dut (.clk(clk), .reset(reset), .bank_sel(bank_sel),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata_q(rdata_q), .addr_base_zero_q(base0),
    .addr_base_one_q(base1), .active_bank_q(act));

  brf_core_model u_core (.clk(clk), .rdata_q(rdata_q),
    .bank_sel(bank_sel), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb));

  // ========================================================================
  // Helpers
  // ========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The upper half of the bus carries noise that a word write must drop.
  task automatic w16(input logic b, input int a, input logic [15:0] v);
    u_core.wr(b, 4'(a), {~v, v});
    sh[b][a] = v;
  endtask

  task automatic c16(input logic b, input int a);
    u_core.rd(b, 4'(a), d);
    check(d, {16'h0, sh[b][a]});
  endtask

  task automatic c_all();
    for (int b = 0; b < 2; b++) begin
      for (int a = 0; a < 7; a++) begin
        c16(b[0], a);
      end
    end
  endtask

  // ========================================================================
  // Scenarios
  // ========================================================================
  task automatic t_reset();
    for (int a = 0; a < 16; a++) begin
      u_core.rd(1'b0, 4'(a), d);
      check(d, 32'h0);
    end
    for (int b = 0; b < 2; b++) begin
      for (int a = 0; a < 7; a++) begin
        sh[b][a] = 16'h0;
      end
    end
    check({base0, base1}, 32'h0);
    check({31'h0, act}, 32'h0);
  endtask

  task automatic t_words();
    for (int b = 0; b < 2; b++) begin
      for (int a = 0; a < 7; a++) begin
        w16(b[0], a, {4'(b + 1), 4'(a), 8'h5a});
      end
    end
    c_all();
  endtask

  task automatic t_bytes();
    w16(1'b0, 0, 16'h1234);
    u_core.wr(1'b0, `BRF_ADR_ZERO_UPPER, 32'hffff_ffab);
    sh[0][0] = 16'hab34;
    c16(1'b0, 0);
    u_core.wr(1'b0, `BRF_ADR_ZERO_LOWER, 32'hffff_ffcd);
    sh[0][0] = 16'habcd;
    c16(1'b0, 0);
    u_core.rd(1'b0, `BRF_ADR_ZERO_UPPER, d);
    check(d, 32'h0000_00ab);
    w16(1'b1, 1, 16'h5678);
    u_core.wr(1'b1, `BRF_ADR_ONE_UPPER, 32'h0000_0022);
    u_core.wr(1'b1, `BRF_ADR_ONE_LOWER, 32'h0000_0011);
    sh[1][1] = 16'h2211;
    c16(1'b1, 1);
    u_core.rd(1'b1, `BRF_ADR_ONE_LOWER, d);
    check(d, 32'h0000_0011);
  endtask

  task automatic t_pairs();
    logic [3:0] pa [3];
    int hi [3];
    int lo [3];
    pa = '{`BRF_ADR_PAIR_LOW_WIDE, `BRF_ADR_PAIR_HIGH_WIDE,
           `BRF_ADR_ADDR_PAIR_WIDE};
    hi = '{2, 3, 5};
    lo = '{0, 1, 4};
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 3; i++) begin
        pv = {4'h9, 4'(i), 4'(b), 8'h16, 4'(i), 4'(b), 4'h2};
        u_core.wr(b[0], pa[i], pv);
        sh[b][hi[i]] = pv[31:16];
        sh[b][lo[i]] = pv[15:0];
        c16(b[0], hi[i]);
        c16(b[0], lo[i]);
        u_core.rd(b[0], pa[i], d);
        check(d, pv);
      end
    end
  endtask

  task automatic t_bases();
    w16(1'b0, 4, 16'h4a4a);
    w16(1'b0, 5, 16'h5b5b);
    @(posedge clk);
    #1;
    check({base0, base1}, {sh[0][4], sh[0][5]});
    u_core.rd(1'b1, 4'h7, d);
    check(d, 32'h0);
    check({base0, base1}, {sh[1][4], sh[1][5]});
    check({31'h0, act}, 32'h1);
    @(posedge clk);
    #1;
    check(rdata_q, 32'h0);
    u_core.wr(1'b1, 4'h7, 32'hffff_ffff);
    u_core.wr(1'b1, `BRF_ADR_STATUS, 32'h0);
    u_core.rd(1'b1, `BRF_ADR_STATUS, d);
    check({31'h0, d[0]}, 32'h1);
    u_core.rd(1'b0, 4'h7, d);
    u_core.rd(1'b0, `BRF_ADR_STATUS, d);
    check({31'h0, d[0]}, 32'h0);
    c_all();
  endtask

  // The second write raises the bank select together with its strobe.
  task automatic t_switch();
    w16(1'b0, 2, 16'h2c2c);
    w16(1'b1, 2, 16'h2d2d);
    c16(1'b0, 2);
    c16(1'b1, 2);
    u_core.wr_rd(1'b1, `BRF_ADR_DATA_THREE, 32'h0000_3e3e, d);
    sh[1][3] = 16'h3e3e;
    check(d, 32'h0000_3e3e);
    c16(1'b1, 3);
  endtask

  task automatic t_rst2();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      for (int a = 0; a < 7; a++) begin
        sh[b][a] = 16'h0;
      end
    end
    c_all();
    check({base0, base1}, 32'h0);
  endtask

  // ========================================================================
  // Main sequence and hang guard
  // ========================================================================
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_words();
    t_bytes();
    t_pairs();
    t_bases();
    t_switch();
    t_rst2();
    end_sim();
  end
endmodule // cpu_banked_register_file_test
